/* File: design/rhw_hour_weekday.sv */
module rhw_hour_weekday
    import rhw_pkg::*;
#(
    parameter int unsigned OSC_FAIL_CYC = OSC_FAIL_CYC_DEF
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       osc_clk,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       hour_carry,
    input  wire logic       power_fail_event,
    output logic      [7:0] hours_value,
    output logic      [7:0] weekday_and_status,
    output logic            stamp_log_enable,
    output logic            backup_supply_enable
);
    rhw_state_t st;
    rhw_state_t next_st;
    logic       osc_toggle;
    logic       osc_edge;
    logic       midnight;
    logic [6:0] next_hours;
    logic [1:0] hr_tens;
    logic [3:0] hr_ones;
    logic       fmt12;
    logic       osc_rst_s1;
    logic       osc_rst_s2;

    // Reset brought into the oscillator domain through two flops
    always_ff @(posedge osc_clk) begin
        osc_rst_s1 <= rst_n;
        osc_rst_s2 <= osc_rst_s1;
    end

    // Oscillator domain: one toggle per oscillator cycle
    always_ff @(posedge osc_clk) begin
        if (!osc_rst_s2) begin
            osc_toggle <= 1'b0;
        end else begin
            osc_toggle <= ~osc_toggle;
        end
    end

    // Field views of the hours register
    assign fmt12   = st.hours[HR_FMT_BIT];
    assign hr_ones = st.hours[HR_ONE_HI_BIT:0];
    assign hr_tens = fmt12 ? {1'b0, st.hours[HR_TEN_LO_BIT]}
                           : st.hours[HR_TEN_HI_BIT:HR_TEN_LO_BIT];
    assign osc_edge = st.sync2 ^ st.sync3;

    // Hour advance in BCD for both formats
    always_comb begin
        next_hours = st.hours;
        midnight   = 1'b0;
        if (fmt12) begin
            if (hr_tens == 2'h1 && hr_ones == 4'h1) begin
                // 11 to 12 flips the meridiem flag
                next_hours[HR_MER_BIT] = ~st.hours[HR_MER_BIT];
                next_hours[HR_ONE_HI_BIT:0] = 4'h2;
                midnight = st.hours[HR_MER_BIT];
            end else if (hr_tens == 2'h1 && hr_ones == 4'h2) begin
                next_hours[HR_TEN_LO_BIT] = 1'b0;
                next_hours[HR_ONE_HI_BIT:0] = 4'h1;
            end else if (hr_ones == 4'h9) begin
                next_hours[HR_TEN_LO_BIT] = 1'b1;
                next_hours[HR_ONE_HI_BIT:0] = 4'h0;
            end else begin
                next_hours[HR_ONE_HI_BIT:0] = hr_ones + 4'h1;
            end
        end else begin
            if (hr_tens == 2'h2 && hr_ones == 4'h3) begin
                next_hours[HR_TEN_HI_BIT:0] = 6'h00;
                midnight = 1'b1;
            end else if (hr_ones == 4'h9) begin
                next_hours[HR_TEN_HI_BIT:HR_TEN_LO_BIT] = hr_tens + 2'h1;
                next_hours[HR_ONE_HI_BIT:0] = 4'h0;
            end else begin
                next_hours[HR_ONE_HI_BIT:0] = hr_ones + 4'h1;
            end
        end
    end

    // Next state of everything on the reference clock
    always_comb begin
        next_st = st;
        // Two-stage crossing of the oscillator toggle, third for edge
        next_st.sync1 = osc_toggle;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;

        // Running flag: count edges, time out when they stop
        if (osc_edge) begin
            next_st.idle = '0;
            if (st.edges != OSC_RUN_EDGES) begin
                next_st.edges = st.edges + 6'h01;
            end
            if (st.edges == OSC_RUN_EDGES - 6'h01) begin
                next_st.osc_run = 1'b1;
            end
        end else if (st.idle >= OSC_FAIL_CYC[FAIL_CNT_W-1:0]) begin
            next_st.osc_run = 1'b0;
            next_st.edges   = '0;
        end else begin
            next_st.idle = st.idle + 1'b1;
        end

        // Timekeeping advance, a register write takes precedence
        if (hour_carry) begin
            next_st.hours = next_hours;
            if (midnight) begin
                next_st.day_of_week_count = (st.day_of_week_count == DAY_OF_WEEK_COUNT_LAST) ? DAY_OF_WEEK_COUNT_FIRST
                              : st.day_of_week_count + 3'h1;
            end
        end
        if (reg_wr && reg_addr == HOURS_OFS) begin
            next_st.hours = reg_wdata[HR_FMT_BIT:0];
        end
        if (reg_wr && reg_addr == WEEKDAY_OFS) begin
            next_st.day_of_week_count    = reg_wdata[WK_DAY_HI_BIT:0];
            next_st.vbat_en  = reg_wdata[WK_VBAT_BIT];
            next_st.pwr_fail = 1'b0;
        end
        // A power-fail event wins over a clearing write
        if (power_fail_event) begin
            next_st.pwr_fail = 1'b1;
        end

        // Registered read data
        case (reg_addr)
            HOURS_OFS:   next_st.rdata = {1'b0, st.hours};
            WEEKDAY_OFS: next_st.rdata = {2'b00, st.osc_run, st.pwr_fail,
                                          st.vbat_en, st.day_of_week_count};
            default:     next_st.rdata = 8'h00;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st       <= '0;
            st.hours <= HOURS_RST;
            st.day_of_week_count <= DAY_OF_WEEK_COUNT_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign reg_rdata            = st.rdata;
    assign hours_value          = {1'b0, st.hours};
    assign weekday_and_status   = {2'b00, st.osc_run, st.pwr_fail,
                                   st.vbat_en, st.day_of_week_count};
    assign stamp_log_enable     = ~st.pwr_fail;
    assign backup_supply_enable = st.vbat_en;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Checks
    hour_msb_zero_a: assert property (
        $past(reg_addr) == HOURS_OFS |-> reg_rdata[7] == 1'b0)
        else $error("hours bit 7 read back as one");
    hour_format_a: assert property (
        reg_wr && reg_addr == HOURS_OFS
        |=> hours_value[HR_FMT_BIT] == $past(reg_wdata[HR_FMT_BIT]))
        else $error("format bit not taken from write");
    meridiem_flip_a: assert property (
        hour_carry && !reg_wr && fmt12 && hr_tens == 2'h1
        && hr_ones == 4'h1
        |=> hours_value[HR_MER_BIT] != $past(hours_value[HR_MER_BIT]))
        else $error("meridiem did not flip at eleven");
    tens_12h_a: assert property (
        hour_carry && !reg_wr && fmt12 && hr_tens == 2'h1
        && hr_ones == 4'h2 |=> hours_value[5:0] == 6'h01
        || hours_value[5:0] == 6'h21)
        else $error("twelve did not roll to one");
    tens_24h_a: assert property (
        hour_carry && !reg_wr && !fmt12 && hr_tens == 2'h2
        && hr_ones == 4'h3 |=> hours_value[5:0] == 6'h00)
        else $error("24-hour rollover wrong");
    ones_wrap_a: assert property (
        hour_carry && !reg_wr && hr_ones == 4'h9
        |=> hours_value[3:0] == 4'h0)
        else $error("ones digit did not wrap");
    day_of_week_count_wrap_a: assert property (
        hour_carry && midnight && !reg_wr && st.day_of_week_count == DAY_OF_WEEK_COUNT_LAST
        |=> weekday_and_status[2:0] == DAY_OF_WEEK_COUNT_FIRST)
        else $error("weekday did not wrap to one");
    day_of_week_count_write_a: assert property (
        reg_wr && reg_addr == WEEKDAY_OFS
        |=> weekday_and_status[2:0] == $past(reg_wdata[2:0]))
        else $error("weekday write lost");
    osc_rise_a: assert property (
        $rose(st.osc_run) |-> $past(st.edges) == OSC_RUN_EDGES - 6'h01)
        else $error("running flag set before 32 edges");
    osc_fall_a: assert property (
        $fell(st.osc_run)
        |-> $past(st.idle) >= OSC_FAIL_CYC[FAIL_CNT_W-1:0])
        else $error("running flag cleared early");
    pf_clear_a: assert property (
        reg_wr && reg_addr == WEEKDAY_OFS && !power_fail_event
        |=> !weekday_and_status[WK_PF_BIT] && stamp_log_enable)
        else $error("power-fail not cleared by write");

    // Read path: unmapped reads zero, mapped reads last cycle's value
    rd_other_a: assert property (
        $past(rst_n) && $past(reg_addr) != HOURS_OFS
        && $past(reg_addr) != WEEKDAY_OFS |-> reg_rdata == 8'h00)
        else $error("unmapped address read back nonzero");
    hour_rdback_a: assert property (
        $past(rst_n) && $past(reg_addr) == HOURS_OFS
        |-> reg_rdata == $past(hours_value))
        else $error("hours read data differs from register");
    wk_rdback_a: assert property (
        $past(rst_n) && $past(reg_addr) == WEEKDAY_OFS
        |-> reg_rdata == $past(weekday_and_status))
        else $error("weekday read data differs from register");

    // Hours register holds unless advanced or written
    hours_hold_a: assert property (
        !hour_carry && !(reg_wr && reg_addr == HOURS_OFS)
        |=> hours_value == $past(hours_value))
        else $error("hours changed without carry or write");
    hour_write_a: assert property (
        reg_wr && reg_addr == HOURS_OFS
        |=> hours_value == {1'b0, $past(reg_wdata[HR_FMT_BIT:0])})
        else $error("hours write not taken over carry");
    fmt_hold_a: assert property (
        hour_carry && !reg_wr
        |=> hours_value[HR_FMT_BIT] == $past(hours_value[HR_FMT_BIT]))
        else $error("hour advance changed the format bit");

    // Twelve-hour digit steps
    mer_hold_a: assert property (
        hour_carry && !reg_wr && fmt12
        && !(hr_tens == 2'h1 && hr_ones == 4'h1)
        |=> hours_value[HR_MER_BIT] == $past(hours_value[HR_MER_BIT]))
        else $error("meridiem changed away from eleven");
    nine_ten_a: assert property (
        hour_carry && !reg_wr && fmt12 && hr_tens == 2'h0
        && hr_ones == 4'h9 |=> hours_value[HR_TEN_LO_BIT:0] == 5'h10)
        else $error("nine did not step to ten");

    // Twenty-four-hour digit steps
    tens_step_a: assert property (
        hour_carry && !reg_wr && !fmt12 && hr_ones == 4'h9
        |=> hours_value[HR_TEN_HI_BIT:HR_TEN_LO_BIT]
            == $past(hours_value[HR_TEN_HI_BIT:HR_TEN_LO_BIT]) + 2'h1)
        else $error("tens digit did not step");
    ones_step_a: assert property (
        hour_carry && !reg_wr && !fmt12 && hr_ones != 4'h9
        && !(hr_tens == 2'h2 && hr_ones == 4'h3)
        |=> hours_value[HR_ONE_HI_BIT:0]
            == $past(hours_value[HR_ONE_HI_BIT:0]) + 4'h1)
        else $error("ones digit did not step");

    // Weekday counter steps and holds
    day_hold_a: assert property (
        !hour_carry && !(reg_wr && reg_addr == WEEKDAY_OFS)
        |=> weekday_and_status[2:0] == $past(weekday_and_status[2:0]))
        else $error("weekday changed without midnight or write");
    day_of_week_count_step_a: assert property (
        hour_carry && midnight && !reg_wr && st.day_of_week_count != DAY_OF_WEEK_COUNT_LAST
        |=> weekday_and_status[2:0] == $past(st.day_of_week_count) + 3'h1)
        else $error("weekday did not step at midnight");
    wk_nocarry_a: assert property (
        hour_carry && midnight && !reg_wr && !power_fail_event
        |=> weekday_and_status[4:3] == $past(weekday_and_status[4:3]))
        else $error("midnight step carried into status bits");
    vbat_write_a: assert property (
        reg_wr && reg_addr == WEEKDAY_OFS
        |=> backup_supply_enable == $past(reg_wdata[WK_VBAT_BIT]))
        else $error("backup enable not taken from write");

    // Power-loss flag set and hold
    pf_set_a: assert property (
        power_fail_event
        |=> weekday_and_status[WK_PF_BIT] && !stamp_log_enable)
        else $error("power-fail event lost");
    pf_hold_a: assert property (
        !power_fail_event && !(reg_wr && reg_addr == WEEKDAY_OFS)
        |=> weekday_and_status[WK_PF_BIT]
            == $past(weekday_and_status[WK_PF_BIT]))
        else $error("power-fail flag changed on its own");

    // Running flag moves only on the right events
    osc_keep_a: assert property (
        st.osc_run && osc_edge |=> st.osc_run)
        else $error("running flag cleared while edges arrive");
    osc_wait_a: assert property (
        !st.osc_run && !osc_edge |=> !st.osc_run)
        else $error("running flag set without an edge");
    osc_restart_a: assert property (
        $fell(st.osc_run) |-> st.edges == 6'h00)
        else $error("edge count kept after a timeout");
endmodule

/* File: design/rhw_pkg.sv */
package rhw_pkg;
    // Register offsets on the register port
    localparam logic [7:0] HOURS_OFS       = 8'h02;
    localparam logic [7:0] WEEKDAY_OFS     = 8'h03;

    // Hours register field positions
    localparam int         HR_FMT_BIT      = 6;
    localparam int         HR_MER_BIT      = 5;
    localparam int         HR_TEN_HI_BIT   = 5;
    localparam int         HR_TEN_LO_BIT   = 4;
    localparam int         HR_ONE_HI_BIT   = 3;

    // Weekday register field positions
    localparam int         WK_RUN_BIT      = 5;
    localparam int         WK_PF_BIT       = 4;
    localparam int         WK_VBAT_BIT     = 3;
    localparam int         WK_DAY_HI_BIT   = 2;

    // Reset values
    localparam logic [6:0] HOURS_RST       = 7'h00;
    localparam logic [2:0] DAY_OF_WEEK_COUNT_RST       = 3'h1;
    localparam logic [2:0] DAY_OF_WEEK_COUNT_FIRST     = 3'h1;
    localparam logic [2:0] DAY_OF_WEEK_COUNT_LAST      = 3'h7;

    // Oscillator status timing
    localparam logic [5:0] OSC_RUN_EDGES   = 6'h20;
    localparam int         CLK_KHZ         = 25000;
    localparam int         OSC_FAIL_US     = 1000;
    localparam int         OSC_FAIL_CYC_DEF = (OSC_FAIL_US * CLK_KHZ) / 1000;
    localparam int         FAIL_CNT_W      = 20;

    typedef struct packed {
        logic [6:0]            hours;
        logic [2:0]            day_of_week_count;
        logic                  vbat_en;
        logic                  pwr_fail;
        logic                  osc_run;
        logic                  sync1;
        logic                  sync2;
        logic                  sync3;
        logic [5:0]            edges;
        logic [FAIL_CNT_W-1:0] idle;
        logic [7:0]            rdata;
    } rhw_state_t;
endpackage

/* File: verif/rhw_osc_src.sv */
// Timebase source, stands still while run is low
module rhw_osc_src (
    input  wire logic run,
    output logic      osc_clk
);
    timeunit 1ns;
    timeprecision 1ps;

    // Half period of 24 ns gives the 48 ns timebase
    initial begin
        osc_clk = 1'b0;
        forever #24 if (run) osc_clk = ~osc_clk;
    end
endmodule

/* File: verif/rhw_hour_weekday_tb_top.sv */
module rhw_hour_weekday_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rhw_pkg::*;

    localparam int FAIL_CYC = 50;
    logic       ref_clk, rst_n, osc_clk, osc_run, reg_wr;
    logic       hour_carry, power_fail_event, stamp_log_enable;
    logic       backup_supply_enable;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [7:0] hours_value, weekday_and_status;
    int         num_errors, num_checks, cyc, h;
    // Steps: 24h midnight, 12h midnight, 12 to 1, 9 to 10, noon, 19 to 20
    logic [7:0] hin [6] = '{8'h23, 8'h71, 8'h52, 8'h49, 8'h51, 8'h19};
    logic [7:0] hout [6] = '{8'h00, 8'h52, 8'h41, 8'h50, 8'h72, 8'h20};

    rhw_hour_weekday #(.OSC_FAIL_CYC(FAIL_CYC)) dut (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .osc_clk              (osc_clk),
        .reg_addr             (reg_addr),
        .reg_wr               (reg_wr),
        .reg_wdata            (reg_wdata),
        .reg_rdata            (reg_rdata),
        .hour_carry           (hour_carry),
        .power_fail_event     (power_fail_event),
        .hours_value          (hours_value),
        .weekday_and_status   (weekday_and_status),
        .stamp_log_enable     (stamp_log_enable),
        .backup_supply_enable (backup_supply_enable)
    );

    rhw_osc_src osc (.run(osc_run), .osc_clk(osc_clk));

    // 40 ns reference clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        step(1);
        check(reg_rdata, exp);
    endtask

    task automatic pulse(ref logic s);
        step(1);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask

    // Two BCD digits of an hour in 24-hour form
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction

    // Main sequence
    initial begin
        {reg_addr, reg_wdata, reg_wr, hour_carry} = '0;
        {power_fail_event, rst_n, osc_run} = 3'b001;
        {num_errors, num_checks, cyc} = '0;
        h = $urandom(32'hB9DA7511);
        step(6);
        rst_n = 1'b1;
        osc_run = 1'b0;
        check(hours_value, 8'h00);
        check(weekday_and_status, 8'h01);
        check({7'h00, stamp_log_enable}, 8'h01);
        rd(8'h07, 8'h00);
        // Random 24h hours with the top bit set on write
        repeat (8) begin
            h = $urandom_range(22, 0);
            wr(HOURS_OFS, bcd(h) | 8'h80);
            rd(HOURS_OFS, bcd(h));
            pulse(hour_carry);
            check(hours_value, bcd(h + 1));
        end
        wr(WEEKDAY_OFS, 8'hFF);
        check(weekday_and_status, 8'h0F);
        check({7'h00, backup_supply_enable}, 8'h01);
        for (int i = 0; i < 6; i++) begin
            wr(HOURS_OFS, hin[i]);
            pulse(hour_carry);
            check(hours_value, hout[i]);
        end
        check(weekday_and_status, 8'h0A);
        pulse(power_fail_event);
        check(weekday_and_status, 8'h1A);
        check({7'h00, stamp_log_enable}, 8'h00);
        wr(WEEKDAY_OFS, 8'h13);
        rd(WEEKDAY_OFS, 8'h03);
        check({7'h00, stamp_log_enable}, 8'h01);
        // Timebase start then failure
        osc_run = 1'b1;
        step(60);
        check(weekday_and_status, 8'h23);
        osc_run = 1'b0;
        step(FAIL_CYC + 10);
        check(weekday_and_status, 8'h03);
        give_verdict();
    end
endmodule
